// ### design/ecvu_defs.svh
`ifndef ECVU_DEFS_SVH
`define ECVU_DEFS_SVH

// Vector offsets
`define ECVU_VEC_NONE   20'h00000
`define ECVU_VEC_DSI    20'h00300
`define ECVU_VEC_ISI    20'h00400
`define ECVU_VEC_EXT    20'h00500
`define ECVU_VEC_ALIGN  20'h00600
`define ECVU_VEC_PROG   20'h00700
`define ECVU_VEC_FPUNAV 20'h00800
`define ECVU_VEC_DEC    20'h00900

// Register byte offsets
`define ECVU_OFF_CTRL   8'h00
`define ECVU_OFF_FPSTAT 8'h04
`define ECVU_OFF_SAVED  8'h08
`define ECVU_OFF_PEND   8'h0C

// Control register fields and reset value
`define ECVU_CTRL_EE    0
`define ECVU_CTRL_PR    1
`define ECVU_CTRL_FE0   2
`define ECVU_CTRL_FE1   3
`define ECVU_CTRL_W     4
`define ECVU_CTRL_RST   4'h0

// Pending bit positions
`define ECVU_P_ISI      0
`define ECVU_P_DSI      1
`define ECVU_P_ALIGN    2
`define ECVU_P_FP       3
`define ECVU_P_ILL      4
`define ECVU_P_PRIV     5
`define ECVU_P_TRAP     6
`define ECVU_P_DEC      7
`define ECVU_PEND_W     8
`define ECVU_PEND_RST   8'h00

// Program cause field inside the pending vector
`define ECVU_PROG_LO    3
`define ECVU_PROG_HI    6
`define ECVU_SAVED_RST  4'h0

// Selected source codes
`define ECVU_SRC_NONE   3'h0
`define ECVU_SRC_ISI    3'h1
`define ECVU_SRC_DSI    3'h2
`define ECVU_SRC_ALIGN  3'h3
`define ECVU_SRC_PROG   3'h4
`define ECVU_SRC_EXT    3'h5
`define ECVU_SRC_DEC    3'h6

`endif

// ### design/ecvu_pkg.sv
package ecvu_pkg;

  // Presentation state
  typedef enum logic {
    ST_IDLE,
    ST_PRESENT
  } ecvu_state_type;

  // Per-cycle event flags from dispatch and completion
  typedef struct packed {
    logic       fetchFault;     // Instruction fetch could not complete
    logic       dataFault;      // Data access could not complete
    logic       srcLoadStore;   // Access came from load/store
    logic       srcMemCtl;      // Access came from memory control op
    logic       srcCacheCtl;    // Access came from cache control op
    logic       alignFault;     // Operand misaligned
    logic       alignMustTrap;  // Misalignment needs the handler
    logic       fpOpEnabledExc; // FP op raised an enabled exception
    logic       fpStatusWrite;  // Move to FP status register
    logic [7:0] fpExcBits;      // Exception bits being written
    logic [7:0] fpEnBits;       // Matching enable bits
    logic       illegalPrimary; // Illegal primary opcode
    logic       illegalCombo;   // Illegal primary/extended pairing
    logic       privOp;         // Privileged operation executed
    logic       sprMove;        // Move to or from special register
    logic       sprInvalid;     // Special-register field invalid
    logic       sprBit0;        // Bit 0 of that field
    logic       trapTaken;      // Trap condition evaluated true
    logic       pipeEmpty;      // All dispatched work completed
    logic       excAck;         // Pipeline took the presented vector
  } ecvu_pipe_type;

  // Exception presented to the pipeline
  typedef struct packed {
    logic        valid;     // A vector is on offer
    logic [19:0] vector;    // Vector offset
    logic [3:0]  progCause; // FP, illegal, privileged, trap
  } ecvu_exc_type;

endpackage

// ### design/exception_cause_vector_unit.sv
// How it works
// RQ1 - Failed data access raises fault at 00300
// RQ2 - Load/store, memory, cache ops cause data faults
// RQ3 - Failed instruction fetch faults at 00400
// RQ4 - External request input vectors to 00500
// RQ5 - Requester holds request until handler starts
// RQ6 - External request stops dispatch, waits drain
// RQ7 - Instruction exceptions go before external interrupt
// RQ8 - Alignment failure vectors to 00600
// RQ9 - Tolerated misalignment completes in hardware
// RQ10 - Program exceptions at 00700, cause recorded
// RQ11 - FP trap when mode bit and summary set
// RQ12 - Summary set by FP op or status write
// RQ13 - Illegal opcodes raise illegal-instruction exception
// RQ14 - Privileged op in user mode traps
// RQ15 - Invalid special register, bit0, user mode traps
// RQ16 - True trap condition raises trap exception
// RQ17 - Vector 00800 is never raised
// RQ18 - Decrementer MSB rising makes 00900 pending
// RQ19 - Decrementer taken only when enabled, else pending
// RQ20 - Async enable masks interrupts; they wait
// RQ21 - One vector at a time, fixed priority
//
// The Wishbone register port and the register offsets were left to the implementer.
`include "ecvu_defs.svh"

module exception_cause_vector_unit
  import ecvu_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clkEn,
  input  wire logic          wbCyc,
  input  wire logic          wbStb,
  input  wire logic          wbWe,
  input  wire logic [31:0]   wbAdr,
  input  wire logic [31:0]   wbDatW,
  input  wire logic [3:0]    wbSel,
  output logic      [31:0]   wbDatR,
  output logic               wbAck,
  input  wire ecvu_pipe_type pipeIn,
  input  wire logic          extIntReq,
  input  wire logic          decMsb,
  output ecvu_exc_type       excOut,
  output logic               dispatchStop,
  output logic               alignFixup
);

  // Software-visible state
  logic [`ECVU_CTRL_W-1:0] machine_state_reg; // EE, PR, FE0, FE1
  logic                    fp_enabled_summary;
  logic [3:0]              saved_status_reg;  // Program cause record
  logic [`ECVU_PEND_W-1:0] pend;              // Held exception causes

  // Internal state
  ecvu_state_type state;
  logic [2:0]     curSrc;       // Source being presented
  logic           decMsbPrev;   // For the rising-edge detect
  logic           fpCondPrev;   // For the FP condition edge

  // Combinational helpers
  logic                    busReq;
  logic                    busWrite;
  logic [`ECVU_PEND_W-1:0] setPend;
  logic [`ECVU_PEND_W-1:0] clrPend;
  logic                    fpCond;
  logic                    userMode;
  logic                    asyncOk;
  logic [2:0]              next_src;
  logic                    takeNow;
  logic                    fpSumSet;

  // Fixed priority pick; instruction causes first
  function automatic logic [2:0] pickSrc(
    input logic [`ECVU_PEND_W-1:0] p,
    input logic                    ext,
    input logic                    ok
  );
    logic [2:0] s;
    s = `ECVU_SRC_NONE;
    if (p[`ECVU_P_ISI]) begin                                  // [RQ21]
      s = `ECVU_SRC_ISI;
    end else if (p[`ECVU_P_DSI]) begin
      s = `ECVU_SRC_DSI;
    end else if (p[`ECVU_P_ALIGN]) begin
      s = `ECVU_SRC_ALIGN;
    end else if (|p[`ECVU_PROG_HI:`ECVU_PROG_LO]) begin
      s = `ECVU_SRC_PROG;
    end else if (ext && ok) begin                              // [RQ7]
      s = `ECVU_SRC_EXT;
    end else if (p[`ECVU_P_DEC] && ok) begin                   // [RQ19]
      s = `ECVU_SRC_DEC;
    end
    return s;
  endfunction

  // Map a source code onto its vector offset
  function automatic logic [19:0] srcVector(input logic [2:0] s);
    logic [19:0] v;
    v = `ECVU_VEC_NONE;
    case (s)
      `ECVU_SRC_DSI:   v = `ECVU_VEC_DSI;                      // [RQ1]
      `ECVU_SRC_ISI:   v = `ECVU_VEC_ISI;                      // [RQ3]
      `ECVU_SRC_EXT:   v = `ECVU_VEC_EXT;                      // [RQ4]
      `ECVU_SRC_ALIGN: v = `ECVU_VEC_ALIGN;                    // [RQ8]
      `ECVU_SRC_PROG:  v = `ECVU_VEC_PROG;                     // [RQ10]
      `ECVU_SRC_DEC:   v = `ECVU_VEC_DEC;                      // [RQ18]
      // FP-unavailable has no source code at all        [RQ17]
      default:         v = `ECVU_VEC_NONE;
    endcase
    return v;
  endfunction

  // Bus request qualifiers
  assign busReq   = wbCyc && wbStb && !wbAck;
  assign busWrite = busReq && wbWe && wbSel[0];

  // Mode bits
  assign userMode = machine_state_reg[`ECVU_CTRL_PR];

  // FP trap condition is a level; edge makes one event
  assign fpCond = (machine_state_reg[`ECVU_CTRL_FE0] ||
                   machine_state_reg[`ECVU_CTRL_FE1]) &&
                  fp_enabled_summary;                          // [RQ11]

  // Summary set sources
  assign fpSumSet = pipeIn.fpOpEnabledExc ||
                    (pipeIn.fpStatusWrite &&
                     |(pipeIn.fpExcBits & pipeIn.fpEnBits));   // [RQ12]

  // Async sources need the enable and a drained pipe
  assign asyncOk = machine_state_reg[`ECVU_CTRL_EE] &&
                   pipeIn.pipeEmpty;                           // [RQ6]

  // New causes arriving this cycle
  always_comb begin
    setPend = `ECVU_PEND_RST;
    setPend[`ECVU_P_ISI]   = pipeIn.fetchFault;                // [RQ3]
    setPend[`ECVU_P_DSI]   = pipeIn.dataFault &&
                             (pipeIn.srcLoadStore ||
                              pipeIn.srcMemCtl ||
                              pipeIn.srcCacheCtl);             // [RQ2]
    setPend[`ECVU_P_ALIGN] = pipeIn.alignFault &&
                             pipeIn.alignMustTrap;             // [RQ8]
    setPend[`ECVU_P_FP]    = fpCond && !fpCondPrev;            // [RQ11]
    setPend[`ECVU_P_ILL]   = pipeIn.illegalPrimary ||
                             pipeIn.illegalCombo;              // [RQ13]
    setPend[`ECVU_P_PRIV]  = userMode &&
                             (pipeIn.privOp ||                 // [RQ14]
                              (pipeIn.sprMove &&
                               pipeIn.sprInvalid &&
                               pipeIn.sprBit0));               // [RQ15]
    setPend[`ECVU_P_TRAP]  = pipeIn.trapTaken;                 // [RQ16]
    setPend[`ECVU_P_DEC]   = decMsb && !decMsbPrev;            // [RQ18]
  end

  // Causes retired by the acknowledged presentation
  always_comb begin
    clrPend = `ECVU_PEND_RST;
    if (state == ST_PRESENT && pipeIn.excAck) begin
      case (curSrc)
        `ECVU_SRC_ISI:   clrPend[`ECVU_P_ISI] = 1'b1;
        `ECVU_SRC_DSI:   clrPend[`ECVU_P_DSI] = 1'b1;
        `ECVU_SRC_ALIGN: clrPend[`ECVU_P_ALIGN] = 1'b1;
        `ECVU_SRC_PROG:  clrPend[`ECVU_PROG_HI:`ECVU_PROG_LO] = 4'hF;
        `ECVU_SRC_DEC:   clrPend[`ECVU_P_DEC] = 1'b1;
        default:         clrPend = `ECVU_PEND_RST;
      endcase
    end
  end

  // Candidate for the next presentation
  assign next_src = pickSrc(pend, extIntReq, asyncOk);
  assign takeNow  = (state == ST_IDLE) &&
                    (next_src != `ECVU_SRC_NONE);

  // Pending causes; a new event beats a clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend <= `ECVU_PEND_RST;
    end else if (clkEn) begin
      pend <= (pend & ~clrPend) | setPend;                     // [RQ21]
    end
  end

  // Edge detect history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      decMsbPrev <= 1'b0;
      fpCondPrev <= 1'b0;
    end else if (clkEn) begin
      decMsbPrev <= decMsb;
      fpCondPrev <= fpCond;
    end
  end

  // Presentation state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state  <= ST_IDLE;
      curSrc <= `ECVU_SRC_NONE;
    end else if (clkEn) begin
      case (state)
        ST_IDLE: begin
          // Source is frozen while it is on offer
          if (takeNow) begin
            state  <= ST_PRESENT;
            curSrc <= next_src;                                // [RQ21]
          end
        end
        ST_PRESENT: begin
          if (pipeIn.excAck) begin
            state  <= ST_IDLE;
            curSrc <= `ECVU_SRC_NONE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Exception output, straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      excOut <= '0;
    end else if (clkEn) begin
      if (takeNow) begin
        excOut.valid     <= 1'b1;
        excOut.vector    <= srcVector(next_src);
        excOut.progCause <= (next_src == `ECVU_SRC_PROG) ?
                            pend[`ECVU_PROG_HI:`ECVU_PROG_LO] :
                            4'h0;
      end else if (state == ST_PRESENT && pipeIn.excAck) begin
        excOut <= '0;
      end
    end
  end

  // Dispatch hold while an enabled async source waits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dispatchStop <= 1'b0;
    end else if (clkEn) begin
      // Request is a level; requester keeps it up      [RQ5]
      dispatchStop <= machine_state_reg[`ECVU_CTRL_EE] &&
                      (extIntReq || pend[`ECVU_P_DEC]);        // [RQ6]
    end
  end

  // Tolerated misalignment: done by hardware, no vector
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alignFixup <= 1'b0;
    end else if (clkEn) begin
      alignFixup <= pipeIn.alignFault &&
                    !pipeIn.alignMustTrap;                     // [RQ9]
    end
  end

  // Program cause record, written when taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saved_status_reg <= `ECVU_SAVED_RST;
    end else if (clkEn) begin
      if (state == ST_PRESENT && pipeIn.excAck &&
          curSrc == `ECVU_SRC_PROG) begin
        saved_status_reg <= excOut.progCause;                  // [RQ10]
      end
    end
  end

  // Mode bits; taking any exception drops the enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      machine_state_reg <= `ECVU_CTRL_RST;
    end else if (clkEn) begin
      if (busWrite && wbAdr == {24'h000000, `ECVU_OFF_CTRL}) begin
        machine_state_reg <= wbDatW[`ECVU_CTRL_W-1:0];
      end else if (state == ST_PRESENT && pipeIn.excAck) begin
        // Stops a held request from re-entering     [RQ20]
        machine_state_reg[`ECVU_CTRL_EE] <= 1'b0;
      end
    end
  end

  // Summary bit; software clears by writing one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fp_enabled_summary <= 1'b0;
    end else if (clkEn) begin
      if (fpSumSet) begin
        fp_enabled_summary <= 1'b1;                            // [RQ12]
      end else if (busWrite && wbDatW[0] &&
                   wbAdr == {24'h000000, `ECVU_OFF_FPSTAT}) begin
        fp_enabled_summary <= 1'b0;
      end
    end
  end

  // Wishbone answer: one cycle, ack drops next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wbAck  <= 1'b0;
      wbDatR <= 32'h00000000;
    end else if (clkEn) begin
      wbAck <= busReq;
      if (busReq && !wbWe) begin
        // Unmapped addresses read as zero
        if (wbAdr == {24'h000000, `ECVU_OFF_CTRL}) begin
          wbDatR <= {28'h0000000, machine_state_reg};
        end else if (wbAdr == {24'h000000, `ECVU_OFF_FPSTAT}) begin
          wbDatR <= {31'h00000000, fp_enabled_summary};
        end else if (wbAdr == {24'h000000, `ECVU_OFF_SAVED}) begin
          wbDatR <= {28'h0000000, saved_status_reg};
        end else if (wbAdr == {24'h000000, `ECVU_OFF_PEND}) begin
          wbDatR <= {20'h00000, 3'h0, (state == ST_PRESENT),
                     pend};
        end else begin
          wbDatR <= 32'h00000000;
        end
      end else begin
        wbDatR <= 32'h00000000;
      end
    end
  end

endmodule

// ### test/ecvu_pipe_model.sv
module ecvu_pipe_model
  import ecvu_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire ecvu_exc_type excOut,
  input  wire logic         dispatchStop,
  input  wire logic [1:0]   ackDelay,
  input  wire logic         extWant,
  output logic              excAck,
  output logic              pipeEmpty,
  output logic              extIntReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] waitCnt;  // Cycles before taking an offer
  logic [1:0] drainCnt; // Work still in flight
  // Take an offered vector after a chosen delay, only while offered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      excAck <= 1'h0;
      waitCnt <= 2'h0;
    end else if (excAck) begin
      excAck <= 1'h0;
      waitCnt <= ackDelay;
    end else if (excOut.valid) begin
      if (waitCnt == 2'h0) excAck <= 1'h1;
      else waitCnt <= waitCnt - 2'h1;
    end
  end
  // Request held until its handler starts
  always_ff @(posedge clk or posedge rst) begin
    if (rst) extIntReq <= 1'h0;
    else if (excAck && excOut.vector == 20'h00500) extIntReq <= 1'h0;
    else if (extWant) extIntReq <= 1'h1;
  end
  // Dispatched work needs a few cycles to complete once stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst || !dispatchStop) begin
      drainCnt <= 2'h3;
      pipeEmpty <= 1'h0;
    end else if (drainCnt != 2'h0) drainCnt <= drainCnt - 2'h1;
    else pipeEmpty <= 1'h1;
  end
endmodule

// ### test/ecvu_sva.sv
module ecvu_sva
  import ecvu_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          clkEn,
  input wire logic          wbCyc,
  input wire logic          wbStb,
  input wire logic          wbAck,
  input wire logic [31:0]   wbDatR,
  input wire ecvu_pipe_type pipeIn,
  input wire ecvu_exc_type  excOut,
  input wire logic          dispatchStop,
  input wire logic          alignFixup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Fault offered at its own offset
  sequence isiShown;
    excOut.valid && excOut.vector == 20'h00400;
  endsequence
  sequence dsiShown;
    excOut.valid && excOut.vector == 20'h00300;
  endsequence
  ack_pulse_a: assert property (wbAck |=> !wbAck)
    else $error("bus ack longer than one cycle");
  ack_latency_a: assert property (wbCyc && wbStb && !wbAck && clkEn |=> wbAck)
    else $error("bus ack not one cycle after request");
  rdata_idle_a: assert property (!wbAck |-> wbDatR == 32'h0)
    else $error("read data outside ack cycle");
  isi_vector_a: assert property (pipeIn.fetchFault |-> ##[2:40] isiShown)
    else $error("fetch fault not vectored");
  dsi_vector_a: assert property (
    pipeIn.dataFault && pipeIn.srcLoadStore |-> ##[2:40] dsiShown)
    else $error("data fault not vectored");
  no_fpunav_a: assert property (excOut.valid |-> excOut.vector != 20'h00800)
    else $error("unimplemented offset offered");
  vec_hold_a: assert property (
    excOut.valid && !pipeIn.excAck |=> $stable(excOut))
    else $error("vector changed before taken");
  vec_clear_a: assert property (excOut.valid && pipeIn.excAck |=> !excOut.valid)
    else $error("vector not withdrawn after take");
  fixup_pulse_a: assert property (
    pipeIn.alignFault && !pipeIn.alignMustTrap |=> alignFixup)
    else $error("tolerated misalign not fixed up");
  ext_stop_a: assert property (
    excOut.valid && excOut.vector == 20'h00500 |-> dispatchStop)
    else $error("external vector without dispatch stop");
  prog_cause_a: assert property (
    excOut.valid && excOut.vector == 20'h00700 |-> excOut.progCause != 4'h0)
    else $error("program vector without cause");
endmodule

bind exception_cause_vector_unit ecvu_sva ecvu_sva_inst (.clk(clk), .rst(rst),
  .clkEn(clkEn), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .wbDatR(wbDatR),
  .pipeIn(pipeIn), .excOut(excOut), .dispatchStop(dispatchStop),
  .alignFixup(alignFixup));

// ### test/exception_cause_vector_unit_tb.sv
module exception_cause_vector_unit_tb
  import ecvu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wbCyc, wbStb, wbWe, wbAck, extIntReq, decMsb, dispatchStop;
  logic alignFixup, excAck, pipeEmpty, extWant, clkEn;
  logic [31:0] wbAdr, wbDatW, wbDatR, rng, q, sr; // sr: bus stall draws
  logic [3:0] wbSel, cause, selV;
  logic [1:0] ackDelay;
  ecvu_pipe_type ev, p, pipeIn;
  ecvu_exc_type excOut;
  logic [23:0] expQ[$]; // Expected vector and cause, in order
  int failures, compares, cycles;

  exception_cause_vector_unit exception_cause_vector_unit_inst (.clk(clk),
    .rst(rst), .clkEn(clkEn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbDatW(wbDatW), .wbSel(wbSel), .wbDatR(wbDatR),
    .wbAck(wbAck), .pipeIn(pipeIn), .extIntReq(extIntReq), .decMsb(decMsb),
    .excOut(excOut), .dispatchStop(dispatchStop), .alignFixup(alignFixup));
  ecvu_pipe_model ecvu_pipe_model_inst (.clk(clk), .rst(rst), .excOut(excOut),
    .dispatchStop(dispatchStop), .ackDelay(ackDelay), .extWant(extWant),
    .excAck(excAck), .pipeEmpty(pipeEmpty), .extIntReq(extIntReq));

  // Pipeline pulses from the bench, handshake from the partner
  always_comb begin
    pipeIn = ev;
    pipeIn.pipeEmpty = pipeEmpty;
    pipeIn.excAck = excAck;
  end
  always #10 clk = ~clk;

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic close_out();
    $display("Mismatches %0d, compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkVec(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t vector %h want %h", $time, got, exp);
    end
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= {24'h0, a};
    wbDatW <= d;
    wbSel <= selV;
    // Random one-cycle freeze delays the answer by a cycle
    sr = nextRand(sr);
    clkEn <= sr[0];
    @(posedge clk);
    clkEn <= 1'h1;
    while (wbAck !== 1'h1) @(posedge clk);
    q = wbDatR;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    chkReg(q, exp);
  endtask
  task automatic pulse(input ecvu_pipe_type v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask
  // Wait for every expected vector, then let the partner idle
  task automatic drain();
    repeat (80) begin
      @(posedge clk);
      if (expQ.size() == 0 && excOut.valid === 1'h0) break;
    end
    if (expQ.size() != 0) begin
      failures++;
      $display("Error %0t expected vector never taken", $time);
    end
    rng = nextRand(rng);
    ackDelay <= rng[1:0];
    repeat (4) @(posedge clk);
  endtask

  // Reference check at every taken vector, plus the run limit
  always @(posedge clk) begin
    cycles++;
    if (!rst && excOut.valid === 1'h1 && excAck === 1'h1) begin
      if (expQ.size() == 0) begin
        failures++;
        $display("Error %0t unexpected vector %h", $time, excOut.vector);
      end else chkVec({excOut.vector, excOut.progCause}, expQ.pop_front());
    end
    if (cycles > 20000) begin
      failures++;
      $display("Error %0t run limit reached", $time);
      close_out();
    end
  end

  initial begin
    {clk, wbCyc, wbStb, wbWe, decMsb, extWant} = 6'h0;
    {wbAdr, wbDatW, wbSel, ackDelay} = 70'h0;
    ev = '0;
    rst = 1'h1;
    rng = 32'h000010F4;
    sr = 32'h000010F4;
    selV = 4'hF;
    clkEn = 1'h1;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 5; i++) rdChk(8'(i * 4), 32'h0);
    rng = nextRand(rng);
    wb(1'h1, 8'h00, rng);
    rdChk(8'h00, {28'h0, rng[3:0]});
    // Write without the low byte lane must be ignored
    selV = 4'hE;
    wb(1'h1, 8'h00, ~rng);
    selV = 4'hF;
    rdChk(8'h00, {28'h0, rng[3:0]});
    wb(1'h1, 8'h08, rng);
    rdChk(8'h08, 32'h0);
    wb(1'h1, 8'h00, 32'h0);
    // Three faults at once leave in fixed order
    p = '0;
    {p.fetchFault, p.dataFault, p.srcLoadStore} = 3'h7;
    {p.alignFault, p.alignMustTrap} = 2'h3;
    expQ = '{24'h004000, 24'h003000, 24'h006000};
    pulse(p);
    drain();
    for (int i = 0; i < 2; i++) begin
      p = '0;
      {p.dataFault, p.srcMemCtl, p.srcCacheCtl} = {1'h1, i == 0, i == 1};
      expQ.push_back(24'h003000);
      pulse(p);
      drain();
    end
    p = '0;
    p.alignFault = 1'h1;
    pulse(p);
    drain();
    rdChk(8'h0C, 32'h0);
    // Illegal, privileged and trap program causes in user mode
    wb(1'h1, 8'h00, 32'h2);
    for (int k = 0; k < 5; k++) begin
      p = '0;
      cause = (k < 2) ? 4'h2 : (k < 4) ? 4'h4 : 4'h8;
      case (k)
        0: p.illegalPrimary = 1'h1;
        1: p.illegalCombo = 1'h1;
        2: p.privOp = 1'h1;
        3: {p.sprMove, p.sprInvalid, p.sprBit0} = 3'h7;
        default: p.trapTaken = 1'h1;
      endcase
      expQ.push_back({20'h00700, cause});
      pulse(p);
      drain();
      rdChk(8'h08, {28'h0, cause});
    end
    wb(1'h1, 8'h00, 32'h0);
    p = '0;
    p.privOp = 1'h1;
    pulse(p);
    drain();
    rdChk(8'h0C, 32'h0);
    // Enabled float exception by operation, then by status write
    wb(1'h1, 8'h00, 32'h4);
    p = '0;
    p.fpOpEnabledExc = 1'h1;
    expQ.push_back(24'h007001);
    pulse(p);
    drain();
    rdChk(8'h04, 32'h1);
    wb(1'h1, 8'h04, 32'h1);
    rdChk(8'h04, 32'h0);
    p = '0;
    {p.fpStatusWrite, p.fpExcBits, p.fpEnBits} = {1'h1, 8'h10, 8'h10};
    expQ.push_back(24'h007001);
    pulse(p);
    drain();
    // External request behind a fetch fault, then masked
    wb(1'h1, 8'h00, 32'h1);
    p = '0;
    p.fetchFault = 1'h1;
    expQ.push_back(24'h004000);
    @(posedge clk);
    extWant <= 1'h1;
    ev <= p;
    @(posedge clk);
    extWant <= 1'h0;
    ev <= '0;
    drain();
    repeat (20) @(posedge clk);
    expQ.push_back(24'h005000);
    wb(1'h1, 8'h00, 32'h1);
    drain();
    // Decrementer edge waits while masked
    wb(1'h1, 8'h00, 32'h0);
    decMsb <= 1'h1;
    repeat (20) @(posedge clk);
    rdChk(8'h0C, 32'h80);
    expQ.push_back(24'h009000);
    wb(1'h1, 8'h00, 32'h1);
    drain();
    close_out();
  end
endmodule
